//--- cbr_pkg.sv
/*
 Constants, register map and state types for the clock buffer
 serial register bank. Assumes a 10 MHz system clock and a
 two-wire serial host that runs its clock far below that rate.
*/
`default_nettype none
package cbr_pkg;

   // Target address and direction bit
   localparam logic [6:0] TARGET_ADDR = 7'h6a;
   localparam logic RW_READ = 1'b1;

   // Register offsets
   localparam logic [7:0] OFF_OE = 8'h00;
   localparam logic [7:0] OFF_DIV_ONE = 8'h01;
   localparam logic [7:0] OFF_DIV_TWO = 8'h02;
   localparam logic [7:0] OFF_RSV_THREE = 8'h03;
   localparam logic [7:0] OFF_RSV_FOUR = 8'h04;
   localparam logic [7:0] OFF_RSV_FIVE = 8'h05;
   localparam logic [7:0] OFF_ID = 8'h06;
   localparam logic [7:0] NUM_REGS = 8'h07;

   // Byte count sent first on a block read
   localparam logic [7:0] READ_COUNT = NUM_REGS;

   // Output enable bit positions and power-up values
   localparam int BIT_OE_THREE = 5;
   localparam int BIT_OE_FOUR = 4;
   localparam logic OE_RST = 1'b1;

   // Divider select power-up values and smallest running setting
   localparam logic [7:0] DIV_ONE_RST = 8'h0f;
   localparam logic [7:0] DIV_TWO_RST = 8'h2e;
   localparam logic [7:0] DIV_MIN = 8'h02;

   // Identification codes, values arbitrary
   localparam logic [3:0] REV_ID = 4'h3;
   localparam logic [3:0] VEN_ID = 4'h5;
   localparam logic [7:0] ID_BYTE = {REV_ID, VEN_ID};

   // Reserved bits read as zero
   localparam logic [7:0] RSV_VALUE = 8'h00;

   // Bits in a serial byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_TX   = 5'b01000,
      ST_HACK = 5'b10000
   } cbr_state_t;

   typedef enum logic [3:0] {
      PH_ADDR   = 4'b0001,
      PH_OFFSET = 4'b0010,
      PH_COUNT  = 4'b0100,
      PH_DATA   = 4'b1000
   } cbr_phase_t;

endpackage
`default_nettype wire

//--- cbr_divider.sv
/*
 Programmable divider for one low-rate output.
 Assumes ref_tick is a one-cycle pulse on clk per reference edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cbr_divider
   import cbr_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // Reference and setting
   input wire logic ref_tick,
   input wire logic [7:0] div_sel,
   // Divided output
   output logic clk_out
);

   logic [7:0] count_q;
   logic [7:0] div_q;
   logic [7:0] count_inc;

   assign count_inc = count_q + 8'h01;

   // New setting is taken at a period boundary, or on any tick while the held setting is below DIV_MIN
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= 8'h00;
         div_q <= 8'h00;
         clk_out <= 1'b0;
      end else if (ce && ref_tick) begin
         if (count_inc >= div_q || div_q < DIV_MIN) begin
            count_q <= 8'h00;
            div_q <= div_sel;
            clk_out <= (div_sel >= DIV_MIN);
         end else begin
            count_q <= count_inc;
            if (count_inc == (div_q >> 1)) begin
               clk_out <= 1'b0;
            end
         end
      end
   end

   a_div_count_bound: assert property (@(posedge clk) disable iff (!reset_n)
      (div_q >= DIV_MIN) |-> (count_q < div_q))
      else $error("divider count beyond setting");
   a_div_low_half: assert property (@(posedge clk) disable iff (!reset_n)
      (div_q >= DIV_MIN && count_q >= (div_q >> 1)) |-> !clk_out)
      else $error("divider output high in low half");

endmodule
`default_nettype wire

//--- cbr_i2c_regs.sv
/*
 Serial target and register bank of a clock distribution buffer.
 Assumes scl_in and sda_in are asynchronous pins, sda driven open
 drain through sda_oe, and ref_tick a same-clock reference pulse.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Acts only as a serial target, block read and write, 7-bit address.
// - Answers address 1101010; write uses byte D4, read uses D5.
// - First byte after write address sets the 8-bit register pointer.
// - Register 0 bits 5 and 4 enable outputs three and four, reset 1.
// - Register 1 is divider select one, reset fifteen.
// - Register 2 is divider select two, reset forty-six.
// - Register 3 is reserved and read-only.
// - Registers 4 and 5 are reserved and read-only.
// - Register 6 holds fixed revision and vendor codes.
// - Write: address, offset, count, data, stop; every byte acknowledged.
// - Read returns count then data; host NACK on last byte ends it.
module cbr_i2c_regs
   import cbr_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // Serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Reference pulse
   input wire logic ref_tick,
   // Output controls
   output logic differential_output_three_en,
   output logic differential_output_four_en,
   output logic programmable_output_one,
   output logic programmable_output_two
);

   cbr_state_t state_q;
   cbr_phase_t phase_q;
   logic scl_m_q, scl_s_q, scl_d_q;
   logic sda_m_q, sda_s_q, sda_d_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic [7:0] ptr_q;
   logic [7:0] cnt_q;
   logic [7:0] div_one_q;
   logic [7:0] div_two_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic byte_done, addr_hit, wr_strobe, tx_load;
   logic [7:0] rd_byte;

   function automatic logic [7:0] reg_read(input logic [7:0] off, input logic e3, input logic e4,
                                           input logic [7:0] d1, input logic [7:0] d2);
      logic [7:0] v;
      v = RSV_VALUE;
      case (off)
         OFF_OE: begin
            v[BIT_OE_THREE] = e3;
            v[BIT_OE_FOUR] = e4;
         end
         OFF_DIV_ONE: v = d1;
         OFF_DIV_TWO: v = d2;
         OFF_ID: v = ID_BYTE;
         default: v = RSV_VALUE;
      endcase
      return v;
   endfunction

   function automatic cbr_phase_t next_phase(input cbr_phase_t p);
      case (p)
         PH_ADDR: return PH_OFFSET;
         PH_OFFSET: return PH_COUNT;
         default: return PH_DATA;
      endcase
   endfunction

   // Pin synchronisers plus one delay stage for edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_d_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else if (ce) begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_d_q <= scl_s_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
         sda_d_q <= sda_s_q;
      end
   end

   assign scl_rise = ce && scl_s_q && !scl_d_q;
   assign scl_fall = ce && !scl_s_q && scl_d_q;
   assign start_det = ce && scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
   assign stop_det = ce && scl_s_q && scl_d_q && !sda_d_q && sda_s_q;
   assign byte_done = (state_q == ST_RX) && scl_fall && (bit_cnt_q == BYTE_BITS);
   assign addr_hit = (shift_q[7:1] == TARGET_ADDR);
   assign wr_strobe = byte_done && (phase_q == PH_DATA) && (cnt_q != 8'h00);
   assign tx_load = (state_q == ST_HACK) && scl_fall;
   assign rd_byte = reg_read(ptr_q, differential_output_three_en, differential_output_four_en,
                             div_one_q, div_two_q);

   // Protocol engine: receive, acknowledge, transmit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         phase_q <= PH_ADDR;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (ce) begin
         if (stop_det) begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (start_det) begin
            state_q <= ST_RX;
            phase_q <= PH_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else begin
            case (state_q)
               ST_RX: begin
                  if (scl_rise && bit_cnt_q != BYTE_BITS) begin
                     shift_q <= {shift_q[6:0], sda_s_q};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (byte_done) begin
                     if (phase_q == PH_ADDR && !addr_hit) begin
                        state_q <= ST_IDLE;
                     end else begin
                        sda_oe <= 1'b1;
                        state_q <= ST_ACK;
                        if (phase_q == PH_ADDR) begin
                           rw_q <= shift_q[0];
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_q <= 4'h0;
                     if (phase_q == PH_ADDR && rw_q == RW_READ) begin
                        tx_q <= READ_COUNT;
                        sda_oe <= ~READ_COUNT[7];
                        state_q <= ST_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        state_q <= ST_RX;
                        phase_q <= next_phase(phase_q);
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == BYTE_BITS - 4'h1) begin
                        sda_oe <= 1'b0;
                        state_q <= ST_HACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe <= ~tx_q[6];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_HACK: begin
                  if (scl_rise && sda_s_q) begin
                     state_q <= ST_IDLE;
                  end else if (scl_fall) begin
                     tx_q <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     bit_cnt_q <= 4'h0;
                     state_q <= ST_TX;
                  end
               end
               ST_IDLE: sda_oe <= 1'b0;
               default: begin
                  state_q <= ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data: only ever pulls low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
      end else if (ce) begin
         sda_out <= 1'b0;
      end
   end

   // Register pointer and write byte count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_q <= 8'h00;
         cnt_q <= 8'h00;
      end else if (ce) begin
         if (byte_done && phase_q == PH_OFFSET) begin
            ptr_q <= shift_q;
         end else if (wr_strobe || tx_load) begin
            ptr_q <= ptr_q + 8'h01;
         end
         if (byte_done && phase_q == PH_COUNT) begin
            cnt_q <= shift_q;
         end else if (wr_strobe) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   // Writable registers; reserved and identification bytes have no storage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         differential_output_three_en <= OE_RST;
         differential_output_four_en <= OE_RST;
         div_one_q <= DIV_ONE_RST;
         div_two_q <= DIV_TWO_RST;
      end else if (ce && wr_strobe) begin
         case (ptr_q)
            OFF_OE: begin
               differential_output_three_en <= shift_q[BIT_OE_THREE];
               differential_output_four_en <= shift_q[BIT_OE_FOUR];
            end
            OFF_DIV_ONE: div_one_q <= shift_q;
            OFF_DIV_TWO: div_two_q <= shift_q;
            default: div_one_q <= div_one_q;
         endcase
      end
   end

   cbr_divider u_div_one (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .ref_tick(ref_tick),
      .div_sel(div_one_q),
      .clk_out(programmable_output_one)
   );

   cbr_divider u_div_two (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .ref_tick(ref_tick),
      .div_sel(div_two_q),
      .clk_out(programmable_output_two)
   );

   a_idle_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == ST_IDLE) |-> !sda_oe)
      else $error("data driven while idle");
   a_addr_miss_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      (byte_done && phase_q == PH_ADDR && !addr_hit && !stop_det && !start_det)
      |=> (state_q == ST_IDLE) && !sda_oe)
      else $error("foreign address acknowledged");
   a_addr_hit_ack: assert property (@(posedge clk) disable iff (!reset_n)
      (byte_done && phase_q == PH_ADDR && addr_hit && !stop_det && !start_det)
      |=> (state_q == ST_ACK) && sda_oe)
      else $error("own address not acknowledged");
   a_offset_loads_ptr: assert property (@(posedge clk) disable iff (!reset_n)
      (byte_done && phase_q == PH_OFFSET) |=> (ptr_q == $past(shift_q)))
      else $error("pointer not loaded from offset byte");
   a_oe_write: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_strobe && ptr_q == OFF_OE)
      |=> (differential_output_three_en == $past(shift_q[BIT_OE_THREE]))
      && (differential_output_four_en == $past(shift_q[BIT_OE_FOUR])))
      else $error("enable bits not written");
   a_div_one_write: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_strobe && ptr_q == OFF_DIV_ONE) |=> (div_one_q == $past(shift_q)))
      else $error("divider one not written");
   a_div_two_write: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_strobe && ptr_q == OFF_DIV_TWO) |=> (div_two_q == $past(shift_q)) && $stable(div_one_q))
      else $error("divider two not written");
   a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
      (ptr_q >= OFF_RSV_THREE && ptr_q <= OFF_RSV_FIVE) |-> (rd_byte == RSV_VALUE))
      else $error("reserved byte not zero");
   a_oe_rsvd_bits: assert property (@(posedge clk) disable iff (!reset_n)
      (ptr_q == OFF_OE) |-> (rd_byte[7:6] == 2'b00) && (rd_byte[3:0] == 4'h0))
      else $error("reserved enable bits not zero");
   a_id_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      (ptr_q == OFF_ID) |-> (rd_byte == ID_BYTE))
      else $error("identification byte wrong");
   a_read_count_first: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == ST_ACK && scl_fall && phase_q == PH_ADDR && rw_q && !stop_det && !start_det)
      |=> (state_q == ST_TX) && (tx_q == READ_COUNT) && (bit_cnt_q == 4'h0))
      else $error("read did not start with count");
   a_data_ack: assert property (@(posedge clk) disable iff (!reset_n)
      (byte_done && phase_q != PH_ADDR && !stop_det && !start_det) |=> sda_oe ##1 (state_q == ST_ACK))
      else $error("data byte not acknowledged");
   a_nack_ends: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == ST_HACK && scl_rise && sda_s_q && !stop_det && !start_det) |=> (state_q == ST_IDLE))
      else $error("host not-acknowledge did not end read");

   c_write_data: cover property (@(posedge clk) disable iff (!reset_n) wr_strobe);
   c_read_byte: cover property (@(posedge clk) disable iff (!reset_n) tx_load);
   c_read_nack: cover property (@(posedge clk) disable iff (!reset_n)
      state_q == ST_HACK && scl_rise && sda_s_q);
   c_addr_miss: cover property (@(posedge clk) disable iff (!reset_n)
      byte_done && phase_q == PH_ADDR && !addr_hit);

endmodule
`default_nettype wire

//--- cbr_i2c_host.sv
/*
 Behavioural two-wire host controller that drives the serial register bank.
 Assumes the bench resolves the data line with a pull-up and calls the
 tasks on a falling edge of the 100 ns system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cbr_i2c_host (
   // Wire side
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // Clock stands high and data released between frames
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Data moves a quarter into the low phase, read back at the end of the high phase
   task automatic put_bit(input logic b, output logic seen);
      #100 sda_pull = ~b;
      #300 scl = 1'b1;
      #400 seen = sda;
      scl = 1'b0;
   endtask

   task automatic start_cond();
      #100 sda_pull = 1'b0;
      #300 scl = 1'b1;
      #400 sda_pull = 1'b1;
      #400 scl = 1'b0;
   endtask

   task automatic stop_cond();
      #100 sda_pull = 1'b1;
      #300 scl = 1'b1;
      #400 sda_pull = 1'b0;
      #400;
   endtask

   // Address, offset, count and data bytes, MSB first, then the ack slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], seen);
      end
      put_bit(1'b1, seen);
      ack = ~seen;
   endtask

   // Host acks every byte but the last, which gets a not-acknowledge
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, seen);
         b[i] = seen;
      end
      put_bit(last, seen);
   endtask
endmodule
`default_nettype wire

//--- tb_cbr_i2c_regs.sv
/*
 Self-checking bench for the clock buffer serial register bank.
 Assumes the host model in cbr_i2c_host and a reference pulse every
 second system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_cbr_i2c_regs
   import cbr_pkg::*;
;
   typedef logic [7:0] cbr_bytes_t [8];
   logic clk, reset_n, ce, ref_tick, scl, host_pull, sda_line;
   logic sda_out, sda_oe, en_three, en_four, prog_one, prog_two;
   int num_errors, comparisons;

   // Open-drain data line with pull-up
   assign sda_line = ~(host_pull | (sda_oe & ~sda_out));

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      ce = 1'b1;
      ref_tick = 1'b0;
      num_errors = 0;
      comparisons = 0;
   end
   always #50 clk = ~clk;
   always @(negedge clk) ref_tick <= ~ref_tick;

   cbr_i2c_regs u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .ref_tick(ref_tick), .differential_output_three_en(en_three),
      .differential_output_four_en(en_four), .programmable_output_one(prog_one),
      .programmable_output_two(prog_two));
   cbr_i2c_host u_host (.scl(scl), .sda_pull(host_pull), .sda(sda_line));

   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic do_write(input logic [7:0] off, input logic [7:0] cnt, input cbr_bytes_t data, input int n);
      logic ack;
      u_host.start_cond();
      u_host.send_byte(8'hd4, ack);
      chk({7'h00, ack}, 8'h01, "write address ack");
      u_host.send_byte(off, ack);
      chk({7'h00, ack}, 8'h01, "offset ack");
      u_host.send_byte(cnt, ack);
      chk({7'h00, ack}, 8'h01, "count ack");
      for (int k = 0; k < n; k++) begin
         u_host.send_byte(data[k], ack);
         chk({7'h00, ack}, 8'h01, "data ack");
      end
      u_host.stop_cond();
   endtask

   // Expected list starts with the count byte
   task automatic do_read(input logic [7:0] off, input cbr_bytes_t exp, input int n);
      logic ack;
      logic [7:0] b;
      u_host.start_cond();
      u_host.send_byte(8'hd4, ack);
      chk({7'h00, ack}, 8'h01, "write address ack");
      u_host.send_byte(off, ack);
      chk({7'h00, ack}, 8'h01, "offset ack");
      u_host.start_cond();
      u_host.send_byte(8'hd5, ack);
      chk({7'h00, ack}, 8'h01, "read address ack");
      for (int k = 0; k < n; k++) begin
         u_host.recv_byte(k == n - 1, b);
         chk(b, exp[k], "read byte");
      end
      u_host.stop_cond();
   endtask

   // Clock cycles between the second and third rising edges of one output
   task automatic period_of(input logic which, input int exp);
      int n, rises;
      logic prev, cur;
      n = 0;
      rises = 0;
      prev = 1'b1;
      for (int c = 0; c < 1000 && rises < 3; c++) begin
         @(negedge clk);
         cur = which ? prog_two : prog_one;
         if (cur === 1'b1 && prev === 1'b0) begin
            rises++;
         end
         if (rises == 2) begin
            n++;
         end
         prev = cur;
      end
      if (rises < 3) begin
         num_errors++;
         $display("BAD at %0t: divided output never toggled", $time);
         tally_and_finish();
      end else begin
         chk(n[7:0], exp[7:0], "divided period");
      end
   endtask

   task automatic t_reset();
      chk({7'h00, en_three}, 8'h01, "output three enable");
      chk({7'h00, en_four}, 8'h01, "output four enable");
      do_read(8'h00, '{READ_COUNT, 8'h30, 8'h0f, 8'h2e, RSV_VALUE, RSV_VALUE, RSV_VALUE, ID_BYTE}, 8);
      period_of(1'b0, 30);
      period_of(1'b1, 92);
      $display("t_reset finished");
   endtask

   task automatic t_enables();
      do_write(8'h00, 8'h01, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      chk({6'h00, en_three, en_four}, 8'h00, "both disabled");
      do_write(8'h00, 8'h01, '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      chk({6'h00, en_three, en_four}, 8'h02, "three only");
      do_write(8'h00, 8'h01, '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
      chk({6'h00, en_three, en_four}, 8'h01, "four only");
      $display("t_enables finished");
   endtask

   task automatic t_divider();
      do_write(8'h01, 8'h02, '{8'h04, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
      do_read(8'h01, '{READ_COUNT, 8'h04, 8'h06, RSV_VALUE, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
      period_of(1'b0, 8);
      period_of(1'b1, 12);
      $display("t_divider finished");
   endtask

   task automatic t_read_only();
      do_write(8'h03, 8'h04, '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
      do_write(8'h01, 8'h01, '{8'h0b, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
      do_read(8'h01, '{READ_COUNT, 8'h0b, 8'h06, RSV_VALUE, RSV_VALUE, RSV_VALUE, ID_BYTE, 8'h00}, 8);
      $display("t_read_only finished");
   endtask

   task automatic t_bad_addr();
      logic ack;
      u_host.start_cond();
      u_host.send_byte(8'haa, ack);
      chk({7'h00, ack}, 8'h00, "foreign address ack");
      u_host.send_byte(8'h00, ack);
      chk({7'h00, ack}, 8'h00, "byte after foreign address");
      u_host.stop_cond();
      chk({6'h00, en_three, en_four}, 8'h01, "enables unchanged");
      $display("t_bad_addr finished");
   endtask

   // Enable low must freeze both dividers, then divider two runs on
   task automatic t_clock_hold();
      logic one, two;
      int moved;
      moved = 0;
      ce = 1'b0;
      one = prog_one;
      two = prog_two;
      for (int c = 0; c < 40; c++) begin
         @(negedge clk);
         if (prog_one !== one || prog_two !== two) begin
            moved++;
         end
      end
      chk(moved[7:0], 8'h00, "outputs moved with enable low");
      ce = 1'b1;
      period_of(1'b1, 12);
      $display("t_clock_hold finished");
   endtask

   task automatic t_second_reset();
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
      chk({6'h00, en_three, en_four}, 8'h03, "enables after reset");
      do_read(8'h00, '{READ_COUNT, 8'h30, 8'h0f, 8'h2e, 8'h00, 8'h00, 8'h00, 8'h00}, 4);
      $display("t_second_reset finished");
   endtask

   initial begin
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      repeat (5) @(negedge clk);
      t_reset();
      t_enables();
      t_divider();
      t_read_only();
      t_bad_addr();
      t_clock_hold();
      t_second_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
